//--- logic/synth_loader_pkg.sv
// Shared constants of the synthesizer divider program loader
package synth_loader_pkg;
  // ==========================================================
  // Widths and divider figures
  localparam int FB_WIDTH = 9;
  localparam int SHIFT_WIDTH = FB_WIDTH + 1;
  localparam int OUT_COUNT = 4;
  localparam int REF_DIVIDE = 16;
  localparam int REF_CNT_WIDTH = 4;
  localparam int FB_CNT_WIDTH = FB_WIDTH + 1;
  localparam logic OUT_SEL_DIV2 = 1'b0;
  localparam logic OUT_SEL_DIV4 = 1'b1;
  // ==========================================================
  // Register map, byte addresses on APB
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h04;
  localparam int CTRL_SOFT_RESET_BIT = 0;
  localparam int STATUS_SEL_BIT = 9;
  localparam int STATUS_PAR_BIT = 10;
  // ==========================================================
  // Values after reset
  localparam logic [FB_WIDTH-1:0] FB_RESET = 9'h000;
  localparam logic [SHIFT_WIDTH-1:0] SHIFT_RESET = 10'h000;
  localparam logic SEL_RESET = 1'b0;
  localparam logic PAR_MODE_RESET = 1'b1;
endpackage : synth_loader_pkg

//--- logic/synth_divider_program_loader.sv
// Divider program loader with reference, feedback and output dividers
`timescale 1ns/10ps
module synth_divider_program_loader
  import synth_loader_pkg::*;
#(
  parameter int FB_BITS = FB_WIDTH
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Parallel programming pins
  input wire logic [FB_BITS-1:0] feedbackDivideBits,
  input wire logic parallelLatchStrobeLow,
  // Serial programming pins
  input wire logic serialClock,
  input wire logic serialData,
  input wire logic serialLoad,
  // Mode pins
  input wire logic masterReset,
  input wire logic referenceSelect,
  input wire logic pllBypassSelect,
  // Reference and VCO sources
  input wire logic crystalInput,
  input wire logic testClock,
  input wire logic vcoPulse,
  output logic crystalDrive,
  // Phase detector strobes
  output logic refPhasePulse,
  output logic fbPhasePulse,
  // Divider state
  output logic [FB_BITS-1:0] feedbackValue,
  output logic outDivideSelect,
  // Clock outputs
  output logic [OUT_COUNT-1:0] clockOutTrue,
  output logic [OUT_COUNT-1:0] clockOutComplement
);

  // ==========================================================
  // Edge detection of the sampled pins
  logic strobePrev_ff;
  logic sClkPrev_ff;
  logic sLoadPrev_ff;
  logic refPrev_ff;
  logic [FB_BITS:0] shift_ff;
  logic [FB_BITS-1:0] fb_ff;
  logic sel_ff;
  logic parMode_ff;
  logic softReset_ff;
  logic divReset;
  logic serialEnable;
  logic shiftEvent;
  logic xferRise;
  logic loadEvent;
  logic [FB_BITS:0] nxt_shift;
  logic refLevel;
  logic refEdge;

  // Previous pin levels for edge finding
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      strobePrev_ff <= 1'b1; // Idle level of the strobe, so no false rise
      sClkPrev_ff <= 1'b0;
      sLoadPrev_ff <= 1'b0;
      refPrev_ff <= 1'b0;
    end else begin
      strobePrev_ff <= parallelLatchStrobeLow;
      sClkPrev_ff <= serialClock;
      sLoadPrev_ff <= serialLoad;
      refPrev_ff <= refLevel;
    end
  end

  // Serial qualifiers; strobe must be high for any serial action
  assign serialEnable = parallelLatchStrobeLow && !serialLoad;
  assign shiftEvent = parallelLatchStrobeLow && serialClock && !sClkPrev_ff;
  assign xferRise = parallelLatchStrobeLow && serialLoad && !sLoadPrev_ff;
  assign nxt_shift = {shift_ff[FB_BITS-1:0], serialData};
  // Load while transfer high includes the freshly shifted bit
  assign loadEvent = xferRise || (shiftEvent && serialLoad && sLoadPrev_ff);

  // ==========================================================
  // Shift register
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      shift_ff <= SHIFT_RESET;
    end else if (shiftEvent) begin
      shift_ff <= nxt_shift;
    end
  end

  // ==========================================================
  // Feedback divide value, unsigned binary
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      fb_ff <= FB_RESET;
    end else if (!parallelLatchStrobeLow) begin
      fb_ff <= feedbackDivideBits;
    end else if (shiftEvent && serialLoad && sLoadPrev_ff) begin
      fb_ff <= nxt_shift[FB_BITS-1:0];
    end else if (xferRise) begin
      fb_ff <= shift_ff[FB_BITS-1:0];
    end
    // Otherwise held, master reset included
  end

  // Output select is written by the serial path alone
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sel_ff <= SEL_RESET;
    end else if (shiftEvent && serialLoad && sLoadPrev_ff) begin
      sel_ff <= nxt_shift[FB_BITS];
    end else if (xferRise) begin
      sel_ff <= shift_ff[FB_BITS];
    end
  end

  // Parallel mode flag: set by strobe low, cleared by serial load
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      parMode_ff <= PAR_MODE_RESET;
    end else if (!parallelLatchStrobeLow) begin
      parMode_ff <= 1'b1;
    end else if (loadEvent) begin
      parMode_ff <= 1'b0;
    end
  end

  // Parallel mode forces /2 without touching the stored select
  assign outDivideSelect = parMode_ff ? OUT_SEL_DIV2 : sel_ff;
  assign feedbackValue = fb_ff;

  // ==========================================================
  // Reference selection and divide by sixteen
  logic [REF_CNT_WIDTH-1:0] refCnt_ff;
  logic refPulse_ff;
  logic xtalDrive_ff;

  assign refLevel = referenceSelect ? crystalInput : testClock;
  assign refEdge = refLevel && !refPrev_ff;
  assign divReset = masterReset || softReset_ff;

  // Oscillator drive is the inverted crystal input
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      xtalDrive_ff <= 1'b1;
    end else begin
      xtalDrive_ff <= !crystalInput;
    end
  end
  assign crystalDrive = xtalDrive_ff;

  // Counter wraps after REF_DIVIDE edges and pulses once
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      refCnt_ff <= '0;
      refPulse_ff <= 1'b0;
    end else if (divReset) begin
      refCnt_ff <= '0;
      refPulse_ff <= 1'b0;
    end else begin
      refPulse_ff <= refEdge && (refCnt_ff == REF_CNT_WIDTH'(REF_DIVIDE - 1));
      if (refEdge) begin
        refCnt_ff <= refCnt_ff + 1'b1;
      end
    end
  end
  assign refPhasePulse = refPulse_ff;

  // ==========================================================
  // Feedback divider: VCO divided by 2M
  logic [FB_BITS:0] fbCnt_ff;
  logic fbPulse_ff;
  logic [FB_BITS:0] fbTerminal;

  // Zero value treated as terminal at once to avoid a stuck count
  assign fbTerminal = (fb_ff == '0) ? '0 : ({fb_ff, 1'b0} - 1'b1);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      fbCnt_ff <= '0;
      fbPulse_ff <= 1'b0;
    end else if (divReset) begin
      fbCnt_ff <= '0;
      fbPulse_ff <= 1'b0;
    end else begin
      fbPulse_ff <= vcoPulse && (fbCnt_ff >= fbTerminal);
      if (vcoPulse) begin
        fbCnt_ff <= (fbCnt_ff >= fbTerminal) ? '0 : fbCnt_ff + 1'b1;
      end
    end
  end
  assign fbPhasePulse = fbPulse_ff;

  // ==========================================================
  // Shared output divider, toggling for 50% duty
  logic outSrc;
  logic halfCnt_ff;
  logic outClk_ff;

  assign outSrc = pllBypassSelect ? vcoPulse : refEdge;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      halfCnt_ff <= 1'b0;
      outClk_ff <= 1'b0;
    end else if (divReset) begin
      halfCnt_ff <= 1'b0;
      outClk_ff <= 1'b0;
    end else if (outSrc) begin
      // Toggle every source pulse for /2, every second one for /4
      if (outDivideSelect == OUT_SEL_DIV2 || halfCnt_ff) begin
        outClk_ff <= !outClk_ff;
        halfCnt_ff <= 1'b0;
      end else begin
        halfCnt_ff <= 1'b1;
      end
    end
  end

  // Per-output drivers from the one divider keep skew equal
  genvar gi;
  generate
    for (gi = 0; gi < OUT_COUNT; gi++) begin : gen_out
      always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
          clockOutTrue[gi] <= 1'b0;
          clockOutComplement[gi] <= 1'b1;
        end else if (divReset) begin
          clockOutTrue[gi] <= 1'b0;
          clockOutComplement[gi] <= 1'b1;
        end else begin
          clockOutTrue[gi] <= outClk_ff;
          clockOutComplement[gi] <= !outClk_ff;
        end
      end
    end
  endgenerate

  // ==========================================================
  // APB slave: zero wait states, error on unmapped address
  logic access;
  logic mapped;
  logic [31:0] nxt_prdata;

  assign access = psel && penable;
  assign mapped = (paddr == CTRL_OFFSET) || (paddr == STATUS_OFFSET);
  assign pready = 1'b1;
  assign pslverr = access && !mapped;

  // Software reset bit holds the dividers like the pin does
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      softReset_ff <= 1'b0;
    end else if (access && pwrite && paddr == CTRL_OFFSET) begin
      softReset_ff <= pwdata[CTRL_SOFT_RESET_BIT];
    end
  end

  // Read word decoded from the address
  always_comb begin
    nxt_prdata = 32'h0000_0000;
    if (paddr == CTRL_OFFSET) begin
      nxt_prdata[CTRL_SOFT_RESET_BIT] = softReset_ff;
    end else if (paddr == STATUS_OFFSET) begin
      nxt_prdata[FB_BITS-1:0] = fb_ff;
      nxt_prdata[STATUS_SEL_BIT] = outDivideSelect;
      nxt_prdata[STATUS_PAR_BIT] = parMode_ff;
    end
  end

  // Captured in the setup phase so the word stands through the access
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable) begin
      prdata <= nxt_prdata;
    end
  end

  // ==========================================================
  // Assertions
  AST_TRANSPARENT: assert property (@(posedge core_clk) disable iff (rst)
    !parallelLatchStrobeLow |=> fb_ff == $past(feedbackDivideBits))
    else $error("feedback value did not follow parallel bits");
  AST_LATCH_HOLD: assert property (@(posedge core_clk) disable iff (rst)
    parallelLatchStrobeLow && !loadEvent ##1 parallelLatchStrobeLow && !loadEvent
    |-> $stable(fb_ff))
    else $error("latched feedback value changed");
  AST_PAR_DIV2: assert property (@(posedge core_clk) disable iff (rst)
    $past(!parallelLatchStrobeLow) |-> outDivideSelect == OUT_SEL_DIV2)
    else $error("parallel mode did not force divide by two");
  AST_SEL_SERIAL_ONLY: assert property (@(posedge core_clk) disable iff (rst)
    !loadEvent |=> $stable(sel_ff))
    else $error("output select changed without serial load");
  AST_SHIFT: assert property (@(posedge core_clk) disable iff (rst)
    shiftEvent |=> shift_ff == {$past(shift_ff[FB_BITS-1:0]), $past(serialData)})
    else $error("shift register did not take serial data");
  AST_TRANSFER: assert property (@(posedge core_clk) disable iff (rst)
    xferRise && !shiftEvent |=> fb_ff == $past(shift_ff[FB_BITS-1:0])
    && sel_ff == $past(shift_ff[FB_BITS]) && !parMode_ff)
    else $error("transfer did not load both dividers");
  AST_RESET_OUT: assert property (@(posedge core_clk) disable iff (rst)
    divReset |=> clockOutTrue == '0 && clockOutComplement == '1)
    else $error("outputs not forced during master reset");
  AST_RESET_KEEP: assert property (@(posedge core_clk) disable iff (rst)
    masterReset && parallelLatchStrobeLow && !loadEvent |=> $stable(fb_ff))
    else $error("master reset disturbed feedback value");
  AST_REF_SPACING: assert property (@(posedge core_clk) disable iff (rst)
    refPhasePulse |=> !refPhasePulse [*8])
    else $error("reference divider pulsed too often");
  AST_DIFF_OUT: assert property (@(posedge core_clk) disable iff (rst)
    !divReset ##1 !divReset |-> clockOutComplement == ~clockOutTrue
    && clockOutTrue == {OUT_COUNT{$past(outClk_ff)}})
    else $error("outputs not a shared complementary pair");
  AST_STROBE_RISE: assert property (@(posedge core_clk) disable iff (rst)
    parallelLatchStrobeLow && !strobePrev_ff |-> fb_ff == $past(feedbackDivideBits))
    else $error("strobe rise did not latch parallel bits");
  AST_SERIAL_GATE: assert property (@(posedge core_clk) disable iff (rst)
    !parallelLatchStrobeLow |=> $stable(shift_ff))
    else $error("shift register moved outside serial operation");
  AST_FALL_HOLD: assert property (@(posedge core_clk) disable iff (rst)
    parallelLatchStrobeLow && !serialLoad && sLoadPrev_ff |=> $stable(fb_ff) && $stable(sel_ff))
    else $error("transfer fall disturbed divider values");
  AST_PASS_THROUGH: assert property (@(posedge core_clk) disable iff (rst)
    shiftEvent && serialLoad && sLoadPrev_ff
    |=> {sel_ff, fb_ff} == {$past(shift_ff[FB_BITS-1:0]), $past(serialData)})
    else $error("serial data not passed to dividers");
  AST_DIV4_HOLD: assert property (@(posedge core_clk) disable iff (rst)
    !divReset && outSrc && outDivideSelect == OUT_SEL_DIV4 && !halfCnt_ff
    |=> $stable(outClk_ff) && halfCnt_ff)
    else $error("divide by four toggled on first source pulse");
  AST_DIV2_TOGGLE: assert property (@(posedge core_clk) disable iff (rst)
    !divReset && outSrc && outDivideSelect == OUT_SEL_DIV2 |=> outClk_ff != $past(outClk_ff))
    else $error("divide by two missed a toggle");
  COV_PARALLEL: cover property (@(posedge core_clk) disable iff (rst)
    !parallelLatchStrobeLow ##1 parallelLatchStrobeLow);
  COV_SERIAL_LOAD: cover property (@(posedge core_clk) disable iff (rst)
    xferRise ##[1:50] !serialLoad);
  COV_DIV4: cover property (@(posedge core_clk) disable iff (rst)
    outDivideSelect == OUT_SEL_DIV4 && outSrc);
  COV_RESET: cover property (@(posedge core_clk) disable iff (rst)
    masterReset ##1 !masterReset);
  COV_SHIFT: cover property (@(posedge core_clk) disable iff (rst)
    serialEnable && shiftEvent);

endmodule : synth_divider_program_loader

//--- tb/prog_controller.sv
// Model of the external controller that drives the programming pins
`timescale 1ns/10ps
module prog_controller (
  // Clock
  input wire logic core_clk,
  // Programming pins
  output logic [8:0] feedbackDivideBits,
  output logic parallelLatchStrobeLow,
  output logic serialClock,
  output logic serialData,
  output logic serialLoad
);
  // ==========================================================
  // Idle levels; every level is held at least two cycles
  initial begin
    feedbackDivideBits = 9'h000;
    parallelLatchStrobeLow = 1'b1;
    serialClock = 1'b0;
    serialData = 1'b0;
    serialLoad = 1'b0;
  end
  task hold(input int n);
    repeat (n) @(posedge core_clk);
  endtask : hold
  // Parallel bits and strobe level
  task par(input logic [8:0] v, input logic s);
    feedbackDivideBits <= v;
    parallelLatchStrobeLow <= s;
    hold(3);
  endtask : par
  // Data flipped after its hold, so a stale bit is never read as valid
  task shift_bit(input logic b);
    serialData <= b;
    hold(2);
    serialClock <= !serialClock;
    hold(2);
    serialClock <= !serialClock;
    serialData <= ~b;
    hold(2);
  endtask : shift_bit
  // Select bit first, then feedback value MSB first
  task shift_word(input logic [9:0] w);
    for (int i = 9; i >= 0; i--) shift_bit(w[i]);
  endtask : shift_word
  task load(input logic v);
    serialLoad <= v;
    hold(3);
  endtask : load
endmodule : prog_controller

//--- tb/tb_top.sv
// Self-checking testbench of the divider program loader
`timescale 1ns/10ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin failures++; \
  $display("[ERR] t=%0t got %0h exp %0h", $time, a, b); end end
module tb_top;
  import synth_loader_pkg::*;
  logic core_clk, rst, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [8:0] bits, feedbackValue;
  logic strobe, sClk, sData, sLoad, masterReset, referenceSelect, pllBypassSelect;
  logic crystalInput, testClock, vcoPulse, crystalDrive, refPhasePulse, fbPhasePulse;
  logic outDivideSelect, er, prevOut;
  logic [3:0] clockOutTrue, clockOutComplement;
  int failures = 0, samples_checked = 0, nRise = 0, nFb = 0, nRef = 0, s0, s1, s2;
  synth_divider_program_loader synth_divider_program_loader_i (.core_clk(core_clk), .rst(rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .feedbackDivideBits(bits),
    .parallelLatchStrobeLow(strobe), .serialClock(sClk), .serialData(sData),
    .serialLoad(sLoad), .masterReset(masterReset), .referenceSelect(referenceSelect),
    .pllBypassSelect(pllBypassSelect), .crystalInput(crystalInput), .testClock(testClock),
    .vcoPulse(vcoPulse), .crystalDrive(crystalDrive), .refPhasePulse(refPhasePulse),
    .fbPhasePulse(fbPhasePulse), .feedbackValue(feedbackValue),
    .outDivideSelect(outDivideSelect), .clockOutTrue(clockOutTrue),
    .clockOutComplement(clockOutComplement));
  prog_controller prog_controller_i (.core_clk(core_clk), .feedbackDivideBits(bits),
    .parallelLatchStrobeLow(strobe), .serialClock(sClk), .serialData(sData),
    .serialLoad(sLoad));
  // ==========================================================
  // Clock, 100 ns period
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  // Edge and pulse counters, read as differences to avoid races
  always @(posedge core_clk) begin
    prevOut <= clockOutTrue[0];
    if (clockOutTrue[0] === 1'b1 && prevOut === 1'b0) nRise++;
    if (fbPhasePulse === 1'b1) nFb++;
    if (refPhasePulse === 1'b1) nRef++;
  end
  // APB transfer; waits on pready, only the watchdog bounds a hang
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask : apb
  // Master reset pin level
  task set_reset(input logic v);
    masterReset <= v;
  endtask : set_reset
  // Master reset clears the dividers, then n source pulses; src 0 vco, 1 crystal, 2 test
  task pulses(input int src, input int n);
    referenceSelect <= (src != 2);
    pllBypassSelect <= (src == 0);
    set_reset(1'b1);
    repeat (3) @(posedge core_clk);
    set_reset(1'b0);
    @(negedge core_clk);
    s0 = nRise;
    s1 = nFb;
    s2 = nRef;
    @(posedge core_clk);
    repeat (n) begin
      for (int v = 1; v >= 0; v--) begin
        if (src == 0) vcoPulse <= v[0];
        else if (src == 1) crystalInput <= v[0];
        else testClock <= v[0];
        repeat (src == 0 ? 1 : 2) @(posedge core_clk);
      end
    end
    repeat (4) @(posedge core_clk);
  endtask : pulses
  task complete_run;
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : complete_run
  // Watchdog, far beyond the few thousand cycles the tests need
  initial begin
    repeat (20000) @(posedge core_clk);
    failures++;
    $display("[ERR] t=%0t watchdog expired", $time);
    complete_run;
  end
  // ==========================================================
  // Test sequence
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {masterReset, testClock, crystalInput, vcoPulse} = '0;
    {referenceSelect, pllBypassSelect} = 2'b11;
    rst = 1'b1;
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    `CHK(outDivideSelect, OUT_SEL_DIV2)
    apb(1'b0, STATUS_OFFSET, 32'h0000_0000);
    `CHK(rd, 32'h0000_0400)
    apb(1'b0, 8'h08, 32'h0000_0000);
    `CHK({er, rd}, {1'b1, 32'h0000_0000})
    $display("test reset done");
    prog_controller_i.par(9'h07d, 1'b0);
    `CHK(feedbackValue, 9'h07d)
    prog_controller_i.par(9'h15e, 1'b0);
    `CHK(feedbackValue, 9'h15e)
    prog_controller_i.par(9'h15e, 1'b1);
    prog_controller_i.par(9'h0c8, 1'b1);
    `CHK({outDivideSelect, feedbackValue}, {OUT_SEL_DIV2, 9'h15e})
    $display("test parallel done");
    prog_controller_i.shift_word({OUT_SEL_DIV4, 9'h080});
    `CHK(feedbackValue, 9'h15e)
    prog_controller_i.load(1'b1);
    `CHK({outDivideSelect, feedbackValue}, {OUT_SEL_DIV4, 9'h080})
    prog_controller_i.load(1'b0);
    apb(1'b0, STATUS_OFFSET, 32'h0000_0000);
    `CHK(rd, 32'h0000_0280)
    prog_controller_i.shift_word({OUT_SEL_DIV2, 9'h096});
    `CHK(feedbackValue, 9'h080)
    pulses(0, 512);
    `CHK(nRise - s0, 128)
    `CHK(nFb - s1, 2)
    `CHK(clockOutComplement, ~clockOutTrue)
    prog_controller_i.load(1'b1);
    `CHK({outDivideSelect, feedbackValue}, {OUT_SEL_DIV2, 9'h096})
    prog_controller_i.shift_bit(1'b1);
    `CHK(feedbackValue, 9'h12d)
    prog_controller_i.load(1'b0);
    $display("test serial done");
    prog_controller_i.shift_word({OUT_SEL_DIV4, 9'h080});
    prog_controller_i.load(1'b1);
    prog_controller_i.load(1'b0);
    prog_controller_i.par(9'h080, 1'b0);
    `CHK(outDivideSelect, OUT_SEL_DIV2)
    apb(1'b0, STATUS_OFFSET, 32'h0000_0000);
    `CHK(rd, 32'h0000_0480)
    pulses(0, 512);
    `CHK(nRise - s0, 256)
    prog_controller_i.par(9'h0c8, 1'b1);
    set_reset(1'b1);
    repeat (3) @(posedge core_clk);
    `CHK({clockOutTrue, clockOutComplement}, 8'h0f)
    `CHK(feedbackValue, 9'h080)
    set_reset(1'b0);
    apb(1'b1, CTRL_OFFSET, 32'h0000_0001);
    apb(1'b0, CTRL_OFFSET, 32'h0000_0000);
    `CHK({rd, clockOutTrue}, {32'h0000_0001, 4'h0})
    apb(1'b1, CTRL_OFFSET, 32'h0000_0000);
    $display("test reset modes done");
    pulses(1, 32);
    `CHK(nRef - s2, 2)
    `CHK(nRise - s0, 16)
    `CHK(crystalDrive, ~crystalInput)
    pulses(2, 32);
    `CHK(nRef - s2, 2)
    `CHK(nRise - s0, 16)
    $display("test reference done");
    complete_run;
  end
endmodule : tb_top
